/* File: prml_regmap.sv */
// Top of the low peripheral register map: scratch RAM and pin/serial/counter
// registers behind AXI4-Lite. Counter and serial engines sit outside and
// exchange live values and command pulses through plain ports.
//
// The implementer's own choice: the AXI4-Lite register port.
module prml_regmap
  import prml_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [PRML_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PRML_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] pinIn,
  output logic [5:0] pinOut,
  output logic [5:0] pinOe,
  output logic [5:0] pinPulldownOn,
  input wire logic pwmSignal,
  input wire logic serialClockSignal,
  input wire logic serialStatusSignal,
  input wire logic freqOutSignal,
  output logic [1:0] fallingEdgeSelect,
  output logic [1:0] debounceBypass,
  output logic [1:0] pinIrqSourceSelect,
  output logic [1:0] wakeOnChangeEnable,
  output logic [1:0] frequencyOutputSelect,
  output logic pinResetSelect,
  output logic inputResetEnable,
  output logic [3:0] serialControlOne,
  output logic [3:0] serialControlTwo,
  input wire logic [1:0] serialStatusIn,
  output logic [7:0] serialData,
  output logic serialDataWrite,
  input wire logic serialDataLoad,
  input wire logic [7:0] serialDataIn,
  output logic [3:0] counterControlOne,
  output logic compareEnable,
  output logic eventCountingSelect,
  output logic counterStart,
  output logic counterLoad,
  output logic [9:0] counterReferenceValue,
  output logic [1:0] compareWidthSelect,
  input wire logic [9:0] counterValue
);
  prml_nib_if nib ();

  prml_axil_slave u_slave (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .nib(nib)
  );

  // Address map decode, shared by the read and write paths
  function automatic logic prml_mapped(input logic [6:0] idx);
    prml_mapped = (idx <= PRML_OFS_PCTL4);
  endfunction

  assign nib.rdHit = prml_mapped(nib.rdIdx);
  assign nib.wrHit = prml_mapped(nib.wrIdx);

  logic [3:0] ram [PRML_RAM_WORDS];
  logic [3:0] pin_output_latch_reg;
  logic [3:0] paOe_reg;
  logic [3:0] pctl1_reg;
  logic [3:0] pctl2_reg;
  logic [3:0] pdDis_reg;
  logic [3:0] odSel_reg;
  logic [3:0] freqRst_reg;
  logic [3:0] sctl1_reg;
  logic [3:0] sctl2_reg;
  logic [7:0] sdata_reg;
  logic [3:0] cctl1_reg;
  logic [2:0] cctl2_reg;
  logic [11:0] cref_reg;
  logic [2:0] paHigh_reg;
  logic [3:0] pctl3_reg;
  logic [3:0] pctl4_reg;
  logic loadPulse_reg;
  logic sdataWr_reg;
  logic wr;
  logic [6:0] wi;

  assign wr = nib.wrEn;
  assign wi = nib.wrIdx;

  // Scratch nibbles carry no reset, so they come up undefined
  always_ff @(posedge clk_sys) begin
    if (wr && wi <= PRML_OFS_RAM_LAST) begin
      ram[wi] <= nib.wrData;
    end
  end

  // Pin bank registers, all cleared by any reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_output_latch_reg <= PRML_RST_NIB;
      paOe_reg <= PRML_RST_NIB;
      pctl1_reg <= PRML_RST_NIB;
      pctl2_reg <= PRML_RST_NIB;
      pdDis_reg <= PRML_RST_NIB;
      odSel_reg <= PRML_RST_NIB;
      paHigh_reg <= 3'h0;
      pctl3_reg <= PRML_RST_NIB;
      pctl4_reg <= PRML_RST_PCTL4;
    end else if (wr) begin
      case (wi)
        PRML_OFS_PA_LOW: pin_output_latch_reg <= nib.wrData;
        PRML_OFS_PA_OE: paOe_reg <= nib.wrData;
        PRML_OFS_PCTL1: pctl1_reg <= nib.wrData;
        PRML_OFS_PCTL2: pctl2_reg <= nib.wrData;
        PRML_OFS_PDDIS: pdDis_reg <= nib.wrData;
        PRML_OFS_ODSEL: odSel_reg <= nib.wrData;
        PRML_OFS_PA_HIGH: paHigh_reg <= nib.wrData[3:1];
        PRML_OFS_PCTL3: pctl3_reg <= nib.wrData;
        PRML_OFS_PCTL4: pctl4_reg <= nib.wrData;
        default: ;
      endcase
    end
  end

  // Serial and frequency registers; the serial engine may reload data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      freqRst_reg <= PRML_RST_NIB;
      sctl1_reg <= PRML_RST_NIB;
      sctl2_reg <= PRML_RST_NIB;
      sdata_reg <= 8'h00;
      sdataWr_reg <= 1'b0;
    end else begin
      sdataWr_reg <= wr && (wi == PRML_OFS_SDATL || wi == PRML_OFS_SDATH);
      if (serialDataLoad) begin
        sdata_reg <= serialDataIn; // Shift result wins over a software write
      end else if (wr && wi == PRML_OFS_SDATL) begin
        sdata_reg[3:0] <= nib.wrData;
      end else if (wr && wi == PRML_OFS_SDATH) begin
        sdata_reg[7:4] <= nib.wrData;
      end
      if (wr && wi == PRML_OFS_FREQRST) begin
        freqRst_reg <= nib.wrData;
      end
      if (wr && wi == PRML_OFS_SCTL1) begin
        sctl1_reg <= nib.wrData;
      end
      if (wr && wi == PRML_OFS_SCTL2) begin
        sctl2_reg <= nib.wrData;
      end
    end
  end

  // Counter registers; load is a one-cycle command, never stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cctl1_reg <= PRML_RST_NIB;
      cctl2_reg <= 3'h0;
      cref_reg <= 12'h000;
      loadPulse_reg <= 1'b0;
    end else begin
      loadPulse_reg <= wr && wi == PRML_OFS_CCTL2 && nib.wrData[0];
      if (wr) begin
        case (wi)
          PRML_OFS_CCTL1: cctl1_reg <= nib.wrData;
          PRML_OFS_CCTL2: cctl2_reg <= nib.wrData[3:1];
          PRML_OFS_CVALL: cref_reg[3:0] <= nib.wrData;
          PRML_OFS_CVALM: cref_reg[7:4] <= nib.wrData;
          PRML_OFS_CVALH: cref_reg[11:8] <= nib.wrData;
          default: ;
        endcase
      end
    end
  end

  // Read multiplexer; pin data reads the live pads
  always_comb begin
    nib.rdData = 4'h0;
    if (nib.rdIdx <= PRML_OFS_RAM_LAST) begin
      nib.rdData = ram[nib.rdIdx];
    end else begin
      case (nib.rdIdx)
        PRML_OFS_PA_LOW: nib.rdData = pinIn[3:0];
        PRML_OFS_PA_OE: nib.rdData = paOe_reg;
        PRML_OFS_PCTL1: nib.rdData = pctl1_reg;
        PRML_OFS_PCTL2: nib.rdData = pctl2_reg;
        PRML_OFS_PDDIS: nib.rdData = pdDis_reg;
        PRML_OFS_ODSEL: nib.rdData = odSel_reg;
        PRML_OFS_FREQRST: nib.rdData = freqRst_reg;
        PRML_OFS_SCTL1: nib.rdData = sctl1_reg;
        PRML_OFS_SCTL2: nib.rdData = {sctl2_reg[3], serialStatusIn[1], sctl2_reg[1:0]};
        PRML_OFS_SDATL: nib.rdData = sdata_reg[3:0];
        PRML_OFS_SDATH: nib.rdData = sdata_reg[7:4];
        PRML_OFS_CCTL1: nib.rdData = cctl1_reg;
        PRML_OFS_CCTL2: nib.rdData = {cctl2_reg, 1'b0};
        PRML_OFS_CVALL: nib.rdData = counterValue[3:0];
        PRML_OFS_CVALM: nib.rdData = counterValue[7:4];
        PRML_OFS_CVALH: nib.rdData = {cref_reg[11:10], counterValue[9:8]};
        // Pin 5 enable and open-drain read back above the live inputs
        PRML_OFS_PA_HIGH: nib.rdData = {paHigh_reg[2:1], pinIn[5:4]};
        PRML_OFS_PCTL3: nib.rdData = pctl3_reg;
        PRML_OFS_PCTL4: nib.rdData = pctl4_reg;
        default: nib.rdData = 4'h0;
      endcase
    end
  end

  // Pin output data after routing of peripheral signals
  logic [5:0] outData;
  logic [5:0] outEn;
  logic [5:0] odMode;
  logic [5:0] pdOff;

  always_comb begin
    outData = {paHigh_reg[0], 1'b0, pin_output_latch_reg};
    if (pctl3_reg[0]) begin
      outData[0] = pwmSignal;
    end
    if (pctl3_reg[1]) begin
      outData[1] = pwmSignal;
    end
    // Serial clock wins over the PWM on pin 1 when software sets both
    if (pctl3_reg[2]) begin
      outData[1] = serialClockSignal;
    end
    if (pctl3_reg[3]) begin
      outData[3] = serialStatusSignal;
    end
    if (pctl4_reg[0]) begin
      outData[2] = freqOutSignal; // Frequency output on pin 2
    end
  end

  // Pin 4 is input only; pin 5 pull-down has no control here
  assign outEn = {paHigh_reg[1], 1'b0, paOe_reg};
  assign odMode = {paHigh_reg[2], 1'b0, odSel_reg};
  assign pdOff = {2'b00, pdDis_reg};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pin
      prml_pin_cell u_pin (
        .outData(outData[g]),
        .outEnable(outEn[g]),
        .openDrain(odMode[g]),
        .pulldownOff(pdOff[g]),
        .padOut(pinOut[g]),
        .padOe(pinOe[g]),
        .padPulldown(pinPulldownOn[g])
      );
    end
  endgenerate

  // Control fields out to the pin, serial and counter logic
  assign fallingEdgeSelect = pctl1_reg[1:0];
  assign debounceBypass = pctl1_reg[3:2];
  assign pinIrqSourceSelect = pctl2_reg[1:0];
  assign wakeOnChangeEnable = pctl2_reg[3:2];
  assign frequencyOutputSelect = freqRst_reg[1:0];
  assign pinResetSelect = freqRst_reg[2];
  assign inputResetEnable = freqRst_reg[3];
  assign serialControlOne = sctl1_reg;
  assign serialControlTwo = sctl2_reg;
  assign serialData = sdata_reg;
  assign serialDataWrite = sdataWr_reg;
  assign counterControlOne = cctl1_reg;
  assign compareEnable = cctl2_reg[0];
  assign eventCountingSelect = cctl2_reg[1];
  assign counterStart = cctl2_reg[2];
  assign counterLoad = loadPulse_reg;
  assign counterReferenceValue = cref_reg[9:0];
  assign compareWidthSelect = cref_reg[11:10];
endmodule

/* File: prml_pkg.sv */
// Constants, offsets and reset values of the low peripheral register map.
// Assumes an AXI4-Lite master with one aligned 32-bit word per nibble register.
// Behaviour
// - Every register loads its reset value at power-up and at each system reset.
// - Low pin data reads live pins 0..3, writes output latch, resets to zero.
// - Output enable bit 1 drives pin as output, 0 leaves it undriven.
// - Pull-down disable bit per pin 0..3, pull-down active by default.
// - Open-drain select per pin 0..3 instead of push-pull output.
// - Control one holds falling-edge select and debounce bypass per pin pair.
// - Control two holds wake-on-change enable and irq source select per pair.
// - Frequency/reset register: 2-bit frequency select, bits 2..3 input reset control.
// - Counter control two bit 0 reads 0, write issues load; bits 1..3 read back.
// - Upper pin register reads pins 4,5; writes pin 5 data, enable, open-drain.
// - Control three routes PWM to pin 0 or 1, serial clock, serial status.
package prml_pkg;
  localparam int unsigned PRML_ADDR_W = 9;
  localparam int unsigned PRML_RAM_WORDS = 80;
  localparam logic [6:0] PRML_OFS_RAM_LAST = 7'h4f;
  localparam logic [6:0] PRML_OFS_PA_LOW = 7'h50;
  localparam logic [6:0] PRML_OFS_PA_OE = 7'h51;
  localparam logic [6:0] PRML_OFS_PCTL1 = 7'h52;
  localparam logic [6:0] PRML_OFS_PCTL2 = 7'h53;
  localparam logic [6:0] PRML_OFS_PDDIS = 7'h54;
  localparam logic [6:0] PRML_OFS_ODSEL = 7'h55;
  localparam logic [6:0] PRML_OFS_FREQRST = 7'h56;
  localparam logic [6:0] PRML_OFS_SCTL1 = 7'h57;
  localparam logic [6:0] PRML_OFS_SCTL2 = 7'h58;
  localparam logic [6:0] PRML_OFS_SDATL = 7'h59;
  localparam logic [6:0] PRML_OFS_SDATH = 7'h5a;
  localparam logic [6:0] PRML_OFS_CCTL1 = 7'h5b;
  localparam logic [6:0] PRML_OFS_CCTL2 = 7'h5c;
  localparam logic [6:0] PRML_OFS_CVALL = 7'h5d;
  localparam logic [6:0] PRML_OFS_CVALM = 7'h5e;
  localparam logic [6:0] PRML_OFS_CVALH = 7'h5f;
  localparam logic [6:0] PRML_OFS_PA_HIGH = 7'h60;
  localparam logic [6:0] PRML_OFS_PCTL3 = 7'h61;
  localparam logic [6:0] PRML_OFS_PCTL4 = 7'h62;
  localparam logic [3:0] PRML_RST_NIB = 4'h0;
  localparam logic [3:0] PRML_RST_PCTL4 = 4'h0;
  localparam logic [1:0] PRML_RESP_OKAY = 2'b00;
  localparam logic [1:0] PRML_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    PRML_IDLE = 2'b00,
    PRML_RESP = 2'b01
  } prml_wstate_e;
endpackage

/* File: prml_nib_if.sv */
// Nibble access channel between the bus slave and the register file.
// Assumes one access per cycle; read data is combinational on the index.
interface prml_nib_if;
  logic wrEn;
  logic [6:0] wrIdx;
  logic [3:0] wrData;
  logic [6:0] rdIdx;
  logic [3:0] rdData;
  logic rdHit;
  logic wrHit;
  modport bus (output wrEn, output wrIdx, output wrData, output rdIdx,
    input rdData, input rdHit, input wrHit);
  modport regs (input wrEn, input wrIdx, input wrData, input rdIdx,
    output rdData, output rdHit, output wrHit);
endinterface

/* File: prml_axil_slave.sv */
// AXI4-Lite slave that turns word accesses into nibble accesses.
// Assumes the register file answers reads in the same cycle.
module prml_axil_slave
  import prml_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [PRML_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [PRML_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  prml_nib_if.bus nib
);
  logic awHeld_reg;
  logic wHeld_reg;
  logic [6:0] awIdx_reg;
  logic [3:0] wNib_reg;
  logic wLane_reg;
  logic doWrite;

  // Address and data are accepted in any order and held until both are in
  assign awready = !awHeld_reg && !bvalid;
  assign wready = !wHeld_reg && !bvalid;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
  assign nib.wrEn = doWrite && wLane_reg && nib.wrHit;
  assign nib.wrIdx = awIdx_reg;
  assign nib.wrData = wNib_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awIdx_reg <= 7'h00;
      wNib_reg <= 4'h0;
      wLane_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= PRML_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awIdx_reg <= awaddr[8:2];
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wNib_reg <= wdata[3:0];
        wLane_reg <= wstrb[0]; // Only lane 0 carries the nibble
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= nib.wrHit ? PRML_RESP_OKAY : PRML_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken
  assign arready = !rvalid;
  assign nib.rdIdx = araddr[8:2];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= PRML_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= {28'h000_0000, nib.rdHit ? nib.rdData : 4'h0};
      rresp <= nib.rdHit ? PRML_RESP_OKAY : PRML_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

/* File: prml_pin_cell.sv */
// One general pin: output data, enable, open-drain and pull-down on/off.
// Assumes the pad resolves the three-signal pin outside the design.
module prml_pin_cell (
  input wire logic outData,
  input wire logic outEnable,
  input wire logic openDrain,
  input wire logic pulldownOff,
  output logic padOut,
  output logic padOe,
  output logic padPulldown
);
  // Open drain only ever pulls low, so it releases the pad on a one
  assign padOut = openDrain ? 1'b0 : outData;
  assign padOe = outEnable && !(openDrain && outData);
  assign padPulldown = !pulldownOff;
endmodule

/* File: prml_regmap_sva.sv */
// Checker for the low peripheral register map, bound to its top module.
// Assumes at most one write and one read in flight on the register bus.
module prml_regmap_sva
  import prml_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [PRML_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PRML_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [5:0] pinIn,
  input wire logic [5:0] pinOe,
  input wire logic [5:0] pinPulldownOn,
  input wire logic [1:0] fallingEdgeSelect,
  input wire logic [1:0] debounceBypass,
  input wire logic [1:0] pinIrqSourceSelect,
  input wire logic [1:0] wakeOnChangeEnable,
  input wire logic [1:0] frequencyOutputSelect,
  input wire logic pinResetSelect,
  input wire logic inputResetEnable,
  input wire logic counterLoad
);
  logic wPend_reg;
  logic [PRML_ADDR_W-1:0] wAddr_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Remembers the write in flight; control outputs may only move under it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wPend_reg <= 1'b0;
      wAddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wPend_reg <= 1'b1;
      wAddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wPend_reg <= 1'b0;
    end
  end

  // Outputs come out of reset in their documented state
  reset_state_a: assert property ($rose(rst_n) |->
    pinPulldownOn == 6'h3f && pinOe == 6'h00 && !counterLoad) else $error("bad reset state");
  pulldown_ctl_a: assert property ($changed(pinPulldownOn) |-> wPend_reg &&
    wAddr_reg == {PRML_OFS_PDDIS, 2'b00}) else $error("pull-down moved");
  pin_low_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == {PRML_OFS_PA_LOW, 2'b00} |=> s_axi_rvalid &&
    s_axi_rdata == {28'h0, $past(pinIn[3:0])}) else $error("low pin read wrong");
  pin_high_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == {PRML_OFS_PA_HIGH, 2'b00} |=> s_axi_rdata[1:0] == $past(pinIn[5:4]))
    else $error("high pin read wrong");
  load_reads_zero_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == {PRML_OFS_CCTL2, 2'b00} |=> !s_axi_rdata[0]) else $error("load bit read 1");
  load_pulse_a: assert property (counterLoad |=> !counterLoad)
    else $error("load pulse too long");
  load_cause_a: assert property ($rose(counterLoad) |-> wPend_reg &&
    wAddr_reg == {PRML_OFS_CCTL2, 2'b00}) else $error("load without write");
  edge_ctl_a: assert property ($changed({fallingEdgeSelect, debounceBypass}) |->
    wPend_reg && wAddr_reg == {PRML_OFS_PCTL1, 2'b00}) else $error("edge control moved");
  wake_ctl_a: assert property ($changed({pinIrqSourceSelect, wakeOnChangeEnable}) |->
    wPend_reg && wAddr_reg == {PRML_OFS_PCTL2, 2'b00}) else $error("wake control moved");
  freq_ctl_a: assert property ($changed({frequencyOutputSelect, pinResetSelect,
    inputResetEnable}) |-> wPend_reg && wAddr_reg == {PRML_OFS_FREQRST, 2'b00})
    else $error("frequency control moved");
endmodule

/* File: prml_regmap_tb.sv */
// Self-checking bench for the low peripheral register map.
// Assumes the package and checker are compiled first; the bench is sole bus master.
module prml_regmap_tb
  import prml_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [8:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, serialControlOne, serialControlTwo, counterControlOne;
  logic [1:0] s_axi_bresp, s_axi_rresp, serialStatusIn, compareWidthSelect;
  logic [5:0] pinIn, pinOut, pinOe, pinPulldownOn;
  logic pwmSignal, serialClockSignal, serialStatusSignal, freqOutSignal, pinResetSelect;
  logic [1:0] fallingEdgeSelect, debounceBypass, pinIrqSourceSelect, wakeOnChangeEnable;
  logic [1:0] frequencyOutputSelect;
  logic inputResetEnable, serialDataWrite, serialDataLoad, compareEnable, eventCountingSelect;
  logic counterStart, counterLoad;
  logic [7:0] serialData, serialDataIn;
  logic [9:0] counterReferenceValue, counterValue;
  logic [33:0] expR[$];
  logic [1:0] expB[$];
  logic [31:0] d;
  logic [6:0] a7;
  logic v;
  int errTotal, totalChecks, cycles, p;

  prml_regmap dut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic completeRun();
    $display("checks=%0d errors=%0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Write with both channels offered together; each dropped once taken
  task automatic wr(input logic [6:0] ofs, input logic [31:0] dat, input logic [1:0] r);
    logic hA, hW, hB;
    @(posedge clk_sys);
    expB.push_back(r);
    s_axi_awaddr <= {ofs, 2'b00};
    s_axi_wdata <= dat;
    s_axi_wstrb <= {3'($urandom), 1'b1};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hB = 1'b0;
    while (!hB) begin
      @(negedge clk_sys);
      hA = s_axi_awvalid && s_axi_awready;
      hW = s_axi_wvalid && s_axi_wready;
      hB = s_axi_bvalid && s_axi_bready;
      @(posedge clk_sys);
      if (hA) s_axi_awvalid <= 1'b0;
      if (hW) s_axi_wvalid <= 1'b0;
      if (hB) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [6:0] ofs, input logic [31:0] dat, input logic [1:0] r);
    logic hA, hR;
    @(posedge clk_sys);
    expR.push_back({r, dat});
    s_axi_araddr <= {ofs, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hR = 1'b0;
    while (!hR) begin
      @(negedge clk_sys);
      hA = s_axi_arvalid && s_axi_arready;
      hR = s_axi_rvalid && s_axi_rready;
      @(posedge clk_sys);
      if (hA) s_axi_arvalid <= 1'b0;
      if (hR) s_axi_rready <= 1'b0;
    end
  endtask

  // Reset release, output state, then every mapped register reads zero
  task automatic resetCheck();
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(34'({pinPulldownOn, pinOe, counterLoad}), 34'({6'h3f, 6'h00, 1'b0}));
    chk(34'({serialControlOne, serialControlTwo, serialData, counterControlOne,
      counterReferenceValue, compareWidthSelect, serialDataWrite}), 34'h0);
    for (int i = 'h50; i <= 'h62; i++) rd(7'(i), 32'h0, PRML_RESP_OKAY);
  endtask

  // Responses are matched against the oldest note in each queue
  always @(negedge clk_sys) begin
    if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(expB.pop_front()));
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expR.pop_front());
  end

  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      completeRun();
    end
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, pinIn} = '0;
    {pwmSignal, serialClockSignal, serialStatusSignal, freqOutSignal} = '0;
    {serialStatusIn, serialDataLoad, serialDataIn, counterValue} = '0;
    void'($urandom(81690));
    resetCheck();
    // Scratch nibbles at both ends and one in between
    for (int i = 0; i < 3; i++) begin
      a7 = (i == 0) ? 7'h00 : (i == 1) ? PRML_OFS_RAM_LAST : 7'($urandom_range(78, 1));
      d = $urandom;
      wr(a7, d, PRML_RESP_OKAY);
      rd(a7, {28'h0, d[3:0]}, PRML_RESP_OKAY);
    end
    // Low pin bank: latch, enable, pull-down and open drain
    pinIn <= 6'($urandom);
    d = $urandom;
    wr(PRML_OFS_PA_LOW, d, PRML_RESP_OKAY);
    wr(PRML_OFS_PA_OE, 32'hf, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'({pinOut[3:0], pinOe[3:0]}), 34'({d[3:0], 4'hf}));
    rd(PRML_OFS_PA_LOW, {28'h0, pinIn[3:0]}, PRML_RESP_OKAY);
    wr(PRML_OFS_PDDIS, 32'h5, PRML_RESP_OKAY);
    wr(PRML_OFS_ODSEL, 32'hf, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'({pinPulldownOn[3:0], pinOe[3:0]}), 34'({4'ha, ~d[3:0]}));
    wr(PRML_OFS_PA_OE, 32'h0, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'(pinOe[3:0]), 34'h0);
    // Edge, wake and frequency controls
    wr(PRML_OFS_PCTL1, 32'h9, PRML_RESP_OKAY);
    wr(PRML_OFS_PCTL2, 32'h6, PRML_RESP_OKAY);
    d = $urandom;
    wr(PRML_OFS_FREQRST, d, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'({fallingEdgeSelect, debounceBypass, pinIrqSourceSelect, wakeOnChangeEnable}),
      34'h69);
    chk(34'({frequencyOutputSelect, pinResetSelect, inputResetEnable}),
      34'({d[1:0], d[2], d[3]}));
    rd(PRML_OFS_FREQRST, {28'h0, d[3:0]}, PRML_RESP_OKAY);
    // Counter control two: load bit reads back zero
    wr(PRML_OFS_CCTL2, 32'hf, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'({counterStart, eventCountingSelect, compareEnable}), 34'h7);
    rd(PRML_OFS_CCTL2, 32'he, PRML_RESP_OKAY);
    // Upper pins: pin 5 latch and enable, inputs of pins 4 and 5
    wr(PRML_OFS_PA_HIGH, 32'h6, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'({pinOut[5], pinOe[5]}), 34'h3);
    rd(PRML_OFS_PA_HIGH, {28'h0, 2'b01, pinIn[5:4]}, PRML_RESP_OKAY);
    // Each route bit in turn, both levels so the latch cannot mask it
    wr(PRML_OFS_ODSEL, 32'h0, PRML_RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr((i == 4) ? PRML_OFS_PCTL4 : PRML_OFS_PCTL3, 32'h1 << (i % 4), PRML_RESP_OKAY);
      p = (i == 4) ? 2 : (i == 3) ? 3 : (i == 0) ? 0 : 1;
      for (int k = 0; k < 2; k++) begin
        @(posedge clk_sys);
        v = k[0];
        {pwmSignal, serialClockSignal, serialStatusSignal, freqOutSignal} <= {4{v}};
        @(negedge clk_sys);
        chk(34'(pinOut[p]), 34'(v));
      end
    end
    // Unmapped places answer with an error
    wr(7'h64, $urandom, PRML_RESP_SLVERR);
    rd(7'h7f, 32'h0, PRML_RESP_SLVERR);
    // Serial and counter registers take nonzero values so the reset has work to do
    d = $urandom | 32'h0001_1111;
    wr(PRML_OFS_SCTL1, d, PRML_RESP_OKAY);
    wr(PRML_OFS_SCTL2, d >> 4, PRML_RESP_OKAY);
    wr(PRML_OFS_SDATH, d >> 8, PRML_RESP_OKAY);
    wr(PRML_OFS_CCTL1, d >> 12, PRML_RESP_OKAY);
    wr(PRML_OFS_CVALH, d >> 16, PRML_RESP_OKAY);
    @(negedge clk_sys);
    chk(34'({compareWidthSelect, counterReferenceValue[9:8], counterControlOne,
      serialData[7:4], serialControlTwo, serialControlOne}), 34'(d[19:0]));
    // Second reset in mid-run restores every register
    pinIn <= 6'h00;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    resetCheck();
    repeat (4) @(posedge clk_sys);
    completeRun();
  end
endmodule

bind prml_regmap prml_regmap_sva chk (.*);
